// ---- hdl/reset_timeout_sequencer.sv ----
`timescale 1ns/1ps
// Reset release sequencer with reset-cause flags and an APB register port.
module reset_timeout_sequencer #(
    parameter int POWER_UP_DELAY_TIMER_TERMINAL = reset_seq_pkg::POWER_UP_DELAY_TIMER_TICKS,
    parameter int OST_TERMINAL = reset_seq_pkg::OST_PERIODS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [reset_seq_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire reset_seq_pkg::cfg_t cfg,
    input wire reset_seq_pkg::events_t events,
    input wire logic external_reset_n,
    input wire logic low_freq_internal_clock,
    input wire logic main_osc_clock,
    input wire logic [reset_seq_pkg::CAL_W-1:0] brownout_cal_fuses,
    output logic core_reset,
    output logic run_enable,
    output logic brownout_enable,
    output logic weak_pullup_enable
);
    import reset_seq_pkg::*;

    typedef struct packed {
        seq_state_t state;
        logic wake_ost;
        logic sleep_prev;
        logic [BOR_CNT_W-1:0] bor_count;
        logic watchdog_expired_n;
        logic sleep_entered_n;
        logic power_on_flag_n;
        logic brownout_flag_n;
        logic software_brownout_enable;
        logic power_up_delay_timer_clear;
        logic ost_clear;
        logic power_up_delay_timer_run;
        logic ost_run;
        logic core_reset;
        logic run_enable;
        logic bor_enable;
        logic weak_pullup;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } seq_regs_t;

    localparam logic [BOR_CNT_W-1:0] BOR_LAST = BOR_CNT_W'(BOR_MIN_CYC - 1);

    seq_regs_t s_r;
    seq_regs_t s_nxt;
    logic lf_tick;
    logic osc_tick;
    logic power_up_delay_timer_done;
    logic ost_done;

    // Tick sources for the two timeout counters.
    edge_tick u_lf_tick (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .slow_in(low_freq_internal_clock),
        .tick(lf_tick)
    );

    edge_tick u_osc_tick (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .slow_in(main_osc_clock),
        .tick(osc_tick)
    );

    // Power-up delay counts low-frequency ticks to a parameterised terminal.
    delay_counter #(
        .TERMINAL(POWER_UP_DELAY_TIMER_TERMINAL)
    ) u_power_up_delay_timer (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clear(s_r.power_up_delay_timer_clear),
        .run(s_r.power_up_delay_timer_run),
        .tick(lf_tick),
        .done(power_up_delay_timer_done)
    );

    // Oscillator start-up counter counts main oscillator periods.
    delay_counter #(
        .TERMINAL(OST_TERMINAL)
    ) u_oscillator_startup_counter (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clear(s_r.ost_clear),
        .run(s_r.ost_run),
        .tick(osc_tick),
        .done(ost_done)
    );

    // Sequencer, flags and bus slave in one next-state process.
    always_comb begin
        logic ext_active;
        logic bor_en;
        logic below;
        logic bor_trip;
        logic crystal;
        logic wake;
        logic setup;
        logic access;
        logic [IDX_W-1:0] idx;
        ext_active = 1'b0;
        bor_en = 1'b0;
        below = 1'b0;
        bor_trip = 1'b0;
        crystal = 1'b0;
        wake = 1'b0;
        setup = 1'b0;
        access = 1'b0;
        idx = paddr[ADDR_W-1:2];
        s_nxt = s_r;
        s_nxt.power_up_delay_timer_clear = 1'b0;
        s_nxt.ost_clear = 1'b0;

        // A cleared pin enable ties the pin reset off and turns on the pull-up.
        ext_active = cfg.external_reset_pin_enable & ~external_reset_n;
        s_nxt.weak_pullup = ~cfg.external_reset_pin_enable;

        // Brown-out mode decode.
        case (cfg.brownout_mode_select)
            BOR_OFF: bor_en = 1'b0;
            BOR_SOFT: bor_en = s_r.software_brownout_enable;
            BOR_HW_SLEEP: bor_en = ~events.sleep_active;
            BOR_ON: bor_en = 1'b1;
            default: bor_en = 1'b0;
        endcase
        s_nxt.bor_enable = bor_en;
        below = bor_en & events.brownout_below;

        // Qualify a low supply for the minimum duration before tripping.
        if (!below) begin
            s_nxt.bor_count = '0;
        end else if (s_r.bor_count != BOR_LAST) begin
            s_nxt.bor_count = s_r.bor_count + 1'b1;
        end
        bor_trip = below && (s_r.bor_count == BOR_LAST);

        crystal = (cfg.osc_mode == OSC_LP) || (cfg.osc_mode == OSC_XT) || (cfg.osc_mode == OSC_HS);
        s_nxt.sleep_prev = events.sleep_active;
        wake = s_r.sleep_prev & ~events.sleep_active;

        // APB write to the power control register; hardware events below override it.
        setup = psel & ~penable;
        access = psel & penable & s_r.pready;
        if (access && pwrite && pstrb[0] && (idx == POWER_CONTROL_IDX)) begin
            s_nxt.software_brownout_enable = pwdata[POWER_CONTROL_SOFTWARE_BROWNOUT_ENABLE_BIT];
            s_nxt.power_on_flag_n = pwdata[POWER_CONTROL_POR_BIT];
            s_nxt.brownout_flag_n = pwdata[POWER_CONTROL_BOR_BIT];
        end

        // Reset-cause flag updates; these win over a software write in the same cycle.
        if (events.por_active) begin
            s_nxt.power_on_flag_n = 1'b0;
            s_nxt.watchdog_expired_n = 1'b1;
            s_nxt.sleep_entered_n = 1'b1;
        end else if (bor_trip) begin
            s_nxt.brownout_flag_n = 1'b0;
            s_nxt.watchdog_expired_n = 1'b1;
            s_nxt.sleep_entered_n = 1'b1;
        end else if (events.wdt_wakeup) begin
            s_nxt.watchdog_expired_n = 1'b0;
            s_nxt.sleep_entered_n = 1'b0;
        end else if (events.wdt_reset) begin
            s_nxt.watchdog_expired_n = 1'b0;
        end else if (ext_active && events.sleep_active) begin
            s_nxt.watchdog_expired_n = 1'b1;
            s_nxt.sleep_entered_n = 1'b0;
        end

        // Timeout sequence; power-on and brown-out take priority over every state.
        if (events.por_active) begin
            s_nxt.state = ST_POR;
            s_nxt.power_up_delay_timer_clear = 1'b1;
            s_nxt.ost_clear = 1'b1;
            s_nxt.wake_ost = 1'b0;
        end else if (bor_trip) begin
            s_nxt.state = ST_BOR;
            s_nxt.power_up_delay_timer_clear = 1'b1;
            s_nxt.ost_clear = 1'b1;
            s_nxt.wake_ost = 1'b0;
        end else begin
            case (s_r.state)
                ST_POR, ST_BOR: begin
                    // Wait for the supply to be back above the threshold.
                    if (!below) begin
                        if (!cfg.power_delay_disable_n) begin
                            s_nxt.state = ST_POWER_UP_DELAY_TIMER;
                        end else if (crystal) begin
                            s_nxt.state = ST_OST;
                        end else begin
                            s_nxt.state = ST_RUN;
                        end
                    end
                end
                ST_POWER_UP_DELAY_TIMER: begin
                    if (power_up_delay_timer_done) begin
                        s_nxt.state = crystal ? ST_OST : ST_RUN;
                    end
                end
                ST_OST: begin
                    if (ost_done) begin
                        s_nxt.state = ST_RUN;
                        s_nxt.wake_ost = 1'b0;
                    end
                end
                ST_RUN: begin
                    // Wake from sleep in crystal modes waits for the oscillator again.
                    if (wake && crystal) begin
                        s_nxt.state = ST_OST;
                        s_nxt.ost_clear = 1'b1;
                        s_nxt.wake_ost = 1'b1;
                    end
                end
                default: begin
                    s_nxt.state = ST_POR;
                    s_nxt.power_up_delay_timer_clear = 1'b1;
                    s_nxt.ost_clear = 1'b1;
                end
            endcase
        end
        s_nxt.power_up_delay_timer_run = (s_nxt.state == ST_POWER_UP_DELAY_TIMER);
        s_nxt.ost_run = (s_nxt.state == ST_OST);

        // Core reset follows the sequence; the pin acts on its own after the timeouts.
        s_nxt.core_reset = (s_nxt.state != ST_RUN && !(s_nxt.state == ST_OST && s_nxt.wake_ost))
            || ext_active || events.wdt_reset;
        s_nxt.run_enable = (s_nxt.state == ST_RUN) && !ext_active && !events.wdt_reset;

        // Bus slave: data is latched in the setup cycle and the access phase ends at once.
        if (setup) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = '0;
            case (idx)
                CORE_STATUS_IDX: begin
                    s_nxt.prdata[STATUS_TO_BIT] = s_r.watchdog_expired_n;
                    s_nxt.prdata[STATUS_PD_BIT] = s_r.sleep_entered_n;
                end
                POWER_CONTROL_IDX: begin
                    s_nxt.prdata[POWER_CONTROL_SOFTWARE_BROWNOUT_ENABLE_BIT] = s_r.software_brownout_enable;
                    s_nxt.prdata[POWER_CONTROL_POR_BIT] = s_r.power_on_flag_n;
                    s_nxt.prdata[POWER_CONTROL_BOR_BIT] = s_r.brownout_flag_n;
                end
                SEQ_STATUS_IDX: begin
                    s_nxt.prdata = {24'h000000, s_r.bor_enable, s_r.run_enable, s_r.core_reset, s_r.state};
                end
                CAL_WORD_IDX: begin
                    // Calibration fuses are read only and no path here can erase them.
                    s_nxt.prdata = {24'h000000, brownout_cal_fuses};
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end else if (access) begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
        end
    end

    // State register; the clock enable freezes everything.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.state <= ST_POR;
            s_r.watchdog_expired_n <= FLAG_RESET;
            s_r.sleep_entered_n <= FLAG_RESET;
            s_r.power_on_flag_n <= 1'b0;
            s_r.brownout_flag_n <= FLAG_RESET;
            s_r.software_brownout_enable <= SOFTWARE_BROWNOUT_ENABLE_RESET;
            s_r.power_up_delay_timer_clear <= 1'b1;
            s_r.ost_clear <= 1'b1;
            s_r.core_reset <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign core_reset = s_r.core_reset;
    assign run_enable = s_r.run_enable;
    assign brownout_enable = s_r.bor_enable;
    assign weak_pullup_enable = s_r.weak_pullup;
endmodule

// ---- hdl/reset_seq_pkg.sv ----
// Behaviour
// - Power-up delay of nominal 64 ms, started only by power-on or brown-out reset.
// - The power-up delay counts low-frequency oscillator ticks, not system clock cycles.
// - Internal reset stays asserted while the power-up delay runs.
// - Delay disable bit at 1 skips the power-up delay; at 0 applies it.
// - Two mode bits give four brown-out modes; mode 01 uses the software enable.
// - Hardware mode disables brown-out detection in sleep and ignores the software enable.
// - Supply below threshold longer than the qualifying time forces brown-out reset.
// - Power-on and brown-out reset wait for supply above threshold, then the enabled 64 ms delay.
// - Brown-out during the delay returns to brown-out reset and restarts the delay.
// - Calibration fuses live in a word at 2008h that bulk erase leaves intact.
// - Power-up delay starts after power-on reset; start-up count after the delay.
// - External clock with the delay disabled leaves reset without any timeout.
// - Timeouts run from power-on regardless of the reset pin; late release runs at once.
// - Crystal modes add 1024 oscillator periods after the delay, alone if no delay or on wake.
// - Brown-out flag cleared by brown-out reset, unchanged on power-on; software sets it.
// - Brown-out flag is meaningless while brown-out mode bits are 00.
// - Power-on flag cleared by power-on reset only; software writes 1 after power-on.
// - Power-on and brown-out set watchdog and sleep flags; watchdog wake-up clears both, watchdog reset only the watchdog flag.
// - Pin reset in sleep sets watchdog flag, clears sleep flag; otherwise flags unchanged.
// - Pin enable bit cleared ties the pin reset inactive and enables a weak pull-up.
package reset_seq_pkg;

    // Bus geometry and register indices; byte address is four times the index.
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] CORE_STATUS_IDX = 10'h003;
    localparam logic [IDX_W-1:0] POWER_CONTROL_IDX = 10'h08E;
    localparam logic [IDX_W-1:0] SEQ_STATUS_IDX = 10'h0A0;
    localparam logic [IDX_W-1:0] CAL_WORD_IDX = 10'h0A1;

    // Field positions.
    localparam int STATUS_TO_BIT = 4;
    localparam int STATUS_PD_BIT = 3;
    localparam int POWER_CONTROL_SOFTWARE_BROWNOUT_ENABLE_BIT = 4;
    localparam int POWER_CONTROL_POR_BIT = 1;
    localparam int POWER_CONTROL_BOR_BIT = 0;

    // Reset values of the watchdog, sleep and brown-out flags and the software enable.
    localparam logic FLAG_RESET = 1'b1;
    localparam logic SOFTWARE_BROWNOUT_ENABLE_RESET = 1'b1;

    // Location of the calibration word in configuration space.
    localparam logic [13:0] CAL_WORD_CFG_ADDR = 14'h2008;
    localparam int CAL_W = 8;

    // Timing: delays in their own units, counts derived from them.
    localparam int CLK_PERIOD_NS = 10;
    localparam longint POWER_UP_DELAY_TIMER_DELAY_US = 64000;
    localparam longint LF_FREQ_HZ = 31000;
    localparam int POWER_UP_DELAY_TIMER_TICKS = int'((POWER_UP_DELAY_TIMER_DELAY_US * LF_FREQ_HZ) / 64'd1000000);
    localparam int OST_PERIODS = 1024;
    localparam int BOR_MIN_NS = 100;
    localparam int BOR_MIN_CYC = (BOR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam int BOR_CNT_W = 8;

    // Brown-out mode encodings.
    localparam logic [1:0] BOR_OFF = 2'h0;
    localparam logic [1:0] BOR_SOFT = 2'h1;
    localparam logic [1:0] BOR_HW_SLEEP = 2'h2;
    localparam logic [1:0] BOR_ON = 2'h3;

    typedef enum logic [2:0] {
        OSC_LP = 3'h0,
        OSC_XT = 3'h1,
        OSC_HS = 3'h2,
        OSC_RC = 3'h3,
        OSC_EC = 3'h4,
        OSC_INT = 3'h5
    } osc_mode_t;

    typedef enum logic [4:0] {
        ST_POR = 5'h01,
        ST_BOR = 5'h02,
        ST_POWER_UP_DELAY_TIMER = 5'h04,
        ST_OST = 5'h08,
        ST_RUN = 5'h10
    } seq_state_t;

    // Configuration fuses.
    typedef struct packed {
        osc_mode_t osc_mode;
        logic power_delay_disable_n;
        logic [1:0] brownout_mode_select;
        logic external_reset_pin_enable;
    } cfg_t;

    // Analog monitors and core events.
    typedef struct packed {
        logic por_active;
        logic brownout_below;
        logic wdt_reset;
        logic wdt_wakeup;
        logic sleep_active;
    } events_t;

endpackage

// ---- hdl/edge_tick.sv ----
`timescale 1ns/1ps
// Turns a slow clock input, sampled on pclk, into one-cycle tick pulses.
module edge_tick (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic slow_in,
    output logic tick
);
    typedef struct packed {
        logic prev;
        logic tick;
    } tick_state_t;

    tick_state_t s_r;
    tick_state_t s_nxt;

    // A rising edge of the slow input gives one tick.
    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = slow_in;
        s_nxt.tick = slow_in & ~s_r.prev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule

// ---- hdl/delay_counter.sv ----
`timescale 1ns/1ps
// Counts ticks up to a terminal count and then holds done until cleared.
module delay_counter #(
    parameter int TERMINAL = 1024
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic clear,
    input wire logic run,
    input wire logic tick,
    output logic done
);
    import reset_seq_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic done;
    } cnt_state_t;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(TERMINAL - 1);

    cnt_state_t s_r;
    cnt_state_t s_nxt;

    // Clear restarts the count; ticks advance it only while running.
    always_comb begin
        s_nxt = s_r;
        if (clear) begin
            s_nxt = '0;
        end else if (run && tick && !s_r.done) begin
            s_nxt.count = s_r.count + 1'b1;
            s_nxt.done = (s_r.count == LAST);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
endmodule

// ---- verification/reset_seq_properties.sv ----
`timescale 1ns/1ps
// Watches the sequencer ports for bus timing, brown-out gating and reset holding.
module reset_seq_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire reset_seq_pkg::cfg_t cfg,
    input wire reset_seq_pkg::events_t events,
    input wire logic external_reset_n,
    input wire logic core_reset,
    input wire logic run_enable,
    input wire logic brownout_enable,
    input wire logic weak_pullup_enable
);
    import reset_seq_pkg::*;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Counts consecutive cycles of low supply seen while detection is enabled.
    logic [7:0] low_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_r <= 8'h00;
        end else if (events.brownout_below && brownout_enable) begin
            low_cnt_r <= (low_cnt_r == 8'hFF) ? low_cnt_r : low_cnt_r + 8'h01;
        end else begin
            low_cnt_r <= 8'h00;
        end
    end

    a_setup_ready: assert property ((ce && psel && !penable) |=> pready)
        else $error("no answer in the first access cycle");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    a_err_zero: assert property (pslverr |-> (pready && prdata == 32'h0))
        else $error("error answer without pready or with data");
    a_por_holds: assert property ((ce && events.por_active) |=> core_reset)
        else $error("core left running under power-on reset");
    a_mode_off: assert property ((cfg.brownout_mode_select == BOR_OFF) |=> !brownout_enable)
        else $error("detection on while mode bits are off");
    a_mode_on: assert property ((cfg.brownout_mode_select == BOR_ON) |=> brownout_enable)
        else $error("detection off in always-on mode");
    a_sleep_off: assert property ((cfg.brownout_mode_select == BOR_HW_SLEEP && events.sleep_active)
        |=> !brownout_enable)
        else $error("detection on during sleep in hardware mode");
    a_trip_reset: assert property ((low_cnt_r >= 8'h0E) |-> core_reset)
        else $error("long brown-out did not reset the core");
    a_pin_reset: assert property ((cfg.external_reset_pin_enable && !external_reset_n) |=> core_reset)
        else $error("active reset pin ignored");
    a_pin_pullup: assert property (!cfg.external_reset_pin_enable |=> weak_pullup_enable)
        else $error("pull-up off while pin reset is disabled");
    a_run_clean: assert property ($rose(run_enable) |-> !core_reset)
        else $error("run enabled while reset held");
endmodule

// ---- verification/supply_model.sv ----
`timescale 1ns/1ps
// Stands in for the supply comparator and the two free-running oscillators.
module supply_model #(
    parameter int LF_HALF_NS = 103,
    parameter int OSC_HALF_NS = 31
) (
    input wire logic supply_low,
    output logic lf_clk,
    output logic osc_clk,
    output logic brownout_below
);
    // Odd half periods keep both oscillators out of phase with pclk.
    initial begin
        lf_clk = 1'b0;
        osc_clk = 1'b0;
    end
    always #(LF_HALF_NS) lf_clk = ~lf_clk;
    always #(OSC_HALF_NS) osc_clk = ~osc_clk;
    // The comparator reports at once; qualifying the length is the block's job.
    assign brownout_below = supply_low;
endmodule

// ---- verification/reset_timeout_sequencer_tb.sv ----
`timescale 1ns/1ps
// Drives the sequencer through power-up, brown-out, watchdog and pin resets.
module reset_timeout_sequencer_tb;
    import reset_seq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cfg_t cfg = '{OSC_RC, 1'b0, BOR_ON, 1'b1};
    events_t ev = '0;
    events_t evt;
    logic external_reset_n = 1'b1;
    logic supply_low = 1'b0;
    logic lf_clk;
    logic osc_clk;
    logic below;
    logic core_reset;
    logic run_enable;
    logic brownout_enable;
    logic weak_pullup_enable;
    logic [31:0] q;
    logic e;
    int n;
    int err_count = 0;
    int n_tests = 0;

    always #5 pclk = ~pclk;

    // The model's comparator output replaces the bench's own brown-out field.
    always_comb begin
        evt = ev;
        evt.brownout_below = below;
    end

    reset_timeout_sequencer #(.POWER_UP_DELAY_TIMER_TERMINAL(8), .OST_TERMINAL(4)) DUT (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg(cfg), .events(evt), .external_reset_n(external_reset_n), .low_freq_internal_clock(lf_clk),
        .main_osc_clock(osc_clk), .brownout_cal_fuses(8'hA5), .core_reset(core_reset),
        .run_enable(run_enable), .brownout_enable(brownout_enable), .weak_pullup_enable(weak_pullup_enable));

    supply_model MODEL (.supply_low(supply_low), .lf_clk(lf_clk), .osc_clk(osc_clk), .brownout_below(below));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is seen at an edge.
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
            k++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic power_up();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic wait_run();
        n = 0;
        while (run_enable !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic see(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // Release time for RC and XT with the delay on, and for EC and HS with it off.
    task automatic test_timeouts();
        osc_mode_t m[4] = '{OSC_RC, OSC_XT, OSC_EC, OSC_HS};
        int lo[4] = '{140, 160, 0, 15};
        int hi[4] = '{200, 235, 6, 35};
        for (int i = 0; i < 4; i++) begin
            cfg.osc_mode <= m[i];
            cfg.power_delay_disable_n <= (i >= 2);
            power_up();
            wait_run();
            chk(32'(n >= lo[i] && n <= hi[i]), 32'h1);
        end
        $display("test_timeouts done");
    endtask

    task automatic test_regs();
        rd(12'h280, 32'hD0);
        rd(12'h238, 32'h11);
        rd(12'h00C, 32'h18);
        rd(12'h284, 32'hA5);
        apb(1'b1, 12'h00C, 32'h0);
        rd(12'h00C, 32'h18);
        apb(1'b1, 12'h238, 32'h13);
        rd(12'h238, 32'h13);
        apb(1'b0, 12'h004, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        $display("test_regs done");
    endtask

    task automatic test_pin_wdt();
        cfg <= '{OSC_RC, 1'b0, BOR_ON, 1'b1};
        external_reset_n <= 1'b0;
        power_up();
        repeat (260) @(posedge pclk);
        external_reset_n <= 1'b1;
        repeat (3) @(posedge pclk);
        see(core_reset, 1'b0);
        ev.wdt_reset <= 1'b1;
        @(posedge pclk);
        ev.wdt_reset <= 1'b0;
        rd(12'h00C, 32'h08);
        ev.wdt_wakeup <= 1'b1;
        @(posedge pclk);
        ev.wdt_wakeup <= 1'b0;
        rd(12'h00C, 32'h00);
        external_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        external_reset_n <= 1'b1;
        rd(12'h00C, 32'h00);
        ev.sleep_active <= 1'b1;
        external_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        external_reset_n <= 1'b1;
        ev.sleep_active <= 1'b0;
        rd(12'h00C, 32'h10);
        cfg.external_reset_pin_enable <= 1'b0;
        external_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        see(core_reset, 1'b0);
        see(weak_pullup_enable, 1'b1);
        cfg.external_reset_pin_enable <= 1'b1;
        external_reset_n <= 1'b1;
        $display("test_pin_wdt done");
    endtask

    // Brown-out during run, then again while the delay counts.
    task automatic test_bor();
        apb(1'b1, 12'h238, 32'h13);
        supply_low <= 1'b1;
        repeat (30) @(posedge pclk);
        see(core_reset, 1'b1);
        rd(12'h238, 32'h12);
        rd(12'h00C, 32'h18);
        supply_low <= 1'b0;
        repeat (60) @(posedge pclk);
        see(core_reset, 1'b1);
        supply_low <= 1'b1;
        repeat (30) @(posedge pclk);
        supply_low <= 1'b0;
        wait_run();
        chk(32'(n >= 140 && n <= 200), 32'h1);
        $display("test_bor done");
    endtask

    task automatic test_modes();
        cfg.brownout_mode_select <= BOR_OFF;
        supply_low <= 1'b1;
        repeat (30) @(posedge pclk);
        see(core_reset | brownout_enable, 1'b0);
        supply_low <= 1'b0;
        cfg.brownout_mode_select <= BOR_SOFT;
        apb(1'b1, 12'h238, 32'h03);
        repeat (2) @(posedge pclk);
        see(brownout_enable, 1'b0);
        apb(1'b1, 12'h238, 32'h13);
        repeat (2) @(posedge pclk);
        see(brownout_enable, 1'b1);
        cfg.brownout_mode_select <= BOR_HW_SLEEP;
        ev.sleep_active <= 1'b1;
        repeat (3) @(posedge pclk);
        see(brownout_enable, 1'b0);
        apb(1'b1, 12'h238, 32'h03);
        ev.sleep_active <= 1'b0;
        repeat (3) @(posedge pclk);
        see(brownout_enable, 1'b1);
        ev.por_active <= 1'b1;
        repeat (3) @(posedge pclk);
        see(core_reset, 1'b1);
        ev.por_active <= 1'b0;
        wait_run();
        chk(32'(n >= 140 && n <= 200), 32'h1);
        $display("test_modes done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        test_timeouts();
        test_regs();
        test_pin_wdt();
        test_bor();
        test_modes();
        end_of_test();
    end

    // Cuts a hang short well after the expected run length.
    initial begin
        #200us;
        err_count++;
        end_of_test();
    end
endmodule

bind reset_timeout_sequencer reset_seq_properties CHK (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg(cfg), .events(events), .external_reset_n(external_reset_n),
    .core_reset(core_reset), .run_enable(run_enable), .brownout_enable(brownout_enable),
    .weak_pullup_enable(weak_pullup_enable));
